//--- pkg/dcpmc_pkg.sv
// Purpose: Shared constants and types for the dual core power mode controller.
// Assumes: One 50 MHz clock, synchronous active low reset.
// Notes: No software registers; control arrives on plain ports.
// Operation
// - Each core keeps its own active or sleep state.
// - Sleeping core clock stops; peripheral and memory clocks keep running.
// - Five ranked states: active, sleep, deep-sleep, power-down, deep power-down.
// - System low-power states shut both cores and non always-on peripherals.
// - Memory power retained according to the selected low-power state.
// - Only an active, enabled core may request system low-power entry.
// - Entry waits until every core whose request was accepted has executed a wait instruction; an enabled core that never requested does not hold entry off.
// - A sleeping core wakes on its own interrupt or event, independently.
// - Interrupts latch in the interrupt controller, events in the event router.
// - System low-power exit only by wake pin or clock or alarm event.
// - Waking from deep power-down asserts a full chip reset.
// - Always-on domain stays powered in every low-power state.
package dcpmc_pkg;
  localparam int NUM_CORES = 2;
  localparam int RESET_PULSE_CYCLES = 16;
  typedef enum logic [1:0]
  {
    DCPMC_MODE_DEEP_SLEEP,
    DCPMC_MODE_POWER_DOWN,
    DCPMC_MODE_DEEP_POWER_DOWN
  } dcpmc_lp_mode_type;
  typedef enum
  {
    DCPMC_SYS_RUN,
    DCPMC_SYS_LOW_POWER,
    DCPMC_SYS_RESET
  } dcpmc_sys_state_type;
  typedef struct packed
  {
    logic core_on;
    logic periph_on;
    logic memory_on;
    logic always_on;
  } dcpmc_power_type;
endpackage

//--- logic/dcpmc_controller.sv
// Purpose: Tracks core sleep, gates core clocks, sequences system low power.
// Assumes: Wait and wake inputs are one-cycle pulses synchronous to clk_in.
// Notes: Power switch outputs are levels; deep power-down exit resets chip.
`timescale 1ns/1ns
module dcpmc_controller #(
  parameter int NUM_CORES = dcpmc_pkg::NUM_CORES,
  parameter int RESET_CYCLES = dcpmc_pkg::RESET_PULSE_CYCLES
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [NUM_CORES-1:0] wait_instruction_in,
  input wire logic [NUM_CORES-1:0] lp_enable_in,
  input wire logic [NUM_CORES-1:0] lp_request_in,
  input wire dcpmc_pkg::dcpmc_lp_mode_type lp_mode_in,
  input wire logic [NUM_CORES-1:0] core_interrupt_controller_wake_in,
  input wire logic [NUM_CORES-1:0] event_router_wake_in,
  input wire logic wake_pin_in,
  input wire logic rtc_event_in,
  input wire logic alarm_event_in,
  output logic [NUM_CORES-1:0] core_clock_enable_out,
  output logic [NUM_CORES-1:0] core_sleeping_out,
  output dcpmc_pkg::dcpmc_power_type power_out,
  output dcpmc_pkg::dcpmc_lp_mode_type active_mode_out,
  output logic system_low_power_out,
  output logic chip_reset_n_out
);
  initial
  begin
    if (NUM_CORES != 2 || RESET_CYCLES < 1)
    begin
      $error("Unsupported dcpmc_controller parameters.");
    end
  end

  dcpmc_pkg::dcpmc_sys_state_type sys_reg;
  dcpmc_pkg::dcpmc_lp_mode_type mode_reg;
  logic [NUM_CORES-1:0] sleep_reg;
  logic [NUM_CORES-1:0] armed_reg;
  logic [NUM_CORES-1:0] waited_reg;
  logic [$clog2(RESET_CYCLES+1)-1:0] rst_cnt_reg;
  logic sys_wake;
  logic all_waited;
  logic any_armed;

  // Only pins and the always-on timers can end a system low-power state.
  assign sys_wake = wake_pin_in | rtc_event_in | alarm_event_in;
  assign any_armed = |armed_reg;
  // Every armed core must have waited; unarmed cores do not hold entry off.
  assign all_waited = any_armed &&
    ((waited_reg | wait_instruction_in | ~armed_reg) == '1);

  // A request counts only from an awake core that is enabled to make it.
  function automatic logic may_arm(
    input logic request,
    input logic enable,
    input logic asleep);
    return request && enable && !asleep;
  endfunction

  function automatic dcpmc_pkg::dcpmc_power_type power_for(
    input dcpmc_pkg::dcpmc_sys_state_type st,
    input dcpmc_pkg::dcpmc_lp_mode_type md);
    dcpmc_pkg::dcpmc_power_type p;
    p = '{core_on: 1'b1, periph_on: 1'b1, memory_on: 1'b1, always_on: 1'b1};
    if (st != dcpmc_pkg::DCPMC_SYS_RUN)
    begin
      p.core_on = 1'b0;
      p.periph_on = 1'b0;
      // Deep power-down drops memory; lighter modes retain it.
      p.memory_on = (md != dcpmc_pkg::DCPMC_MODE_DEEP_POWER_DOWN);
    end
    p.always_on = 1'b1;
    return p;
  endfunction

  // Per-core arming for system entry: only active, enabled cores qualify.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || sys_reg != dcpmc_pkg::DCPMC_SYS_RUN)
    begin
      armed_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CORES; i++)
      begin
        if (may_arm(lp_request_in[i], lp_enable_in[i],
                    sleep_reg[i]))
        begin
          armed_reg[i] <= 1'b1;
        end
        else if (!lp_enable_in[i])
        begin
          armed_reg[i] <= 1'b0;
        end
      end
    end
  end

  // The mode must outlive entry: it decides memory retention and whether
  // the wake-up ends in a chip reset, so only rst_n_in clears it; the chip reset pulse leaves it set.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      mode_reg <= dcpmc_pkg::DCPMC_MODE_DEEP_SLEEP;
    end
    else if (sys_reg == dcpmc_pkg::DCPMC_SYS_RUN)
    begin
      for (int i = 0; i < NUM_CORES; i++)
      begin
        if (may_arm(lp_request_in[i], lp_enable_in[i],
                    sleep_reg[i]))
        begin
          mode_reg <= lp_mode_in;
        end
      end
    end
  end

  // Per-core sleep state with independent wake-up.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || sys_reg != dcpmc_pkg::DCPMC_SYS_RUN)
    begin
      sleep_reg <= '0;
      waited_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CORES; i++)
      begin
        if (core_interrupt_controller_wake_in[i] ||
            event_router_wake_in[i])
        begin
          sleep_reg[i] <= 1'b0;
          waited_reg[i] <= 1'b0;
        end
        else if (wait_instruction_in[i] && !sleep_reg[i])
        begin
          sleep_reg[i] <= 1'b1;
          waited_reg[i] <= armed_reg[i];
        end
      end
    end
  end

  // System state: run, low power, or the reset pulse after deep power-down.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sys_reg <= dcpmc_pkg::DCPMC_SYS_RUN;
      rst_cnt_reg <= '0;
    end
    else
    begin
      unique case (sys_reg)
        dcpmc_pkg::DCPMC_SYS_RUN:
        begin
          if (all_waited)
          begin
            sys_reg <= dcpmc_pkg::DCPMC_SYS_LOW_POWER;
          end
        end
        dcpmc_pkg::DCPMC_SYS_LOW_POWER:
        begin
          if (sys_wake && mode_reg == dcpmc_pkg::DCPMC_MODE_DEEP_POWER_DOWN)
          begin
            sys_reg <= dcpmc_pkg::DCPMC_SYS_RESET;
            rst_cnt_reg <= ($clog2(RESET_CYCLES+1))'(RESET_CYCLES);
          end
          else if (sys_wake)
          begin
            sys_reg <= dcpmc_pkg::DCPMC_SYS_RUN;
          end
        end
        dcpmc_pkg::DCPMC_SYS_RESET:
        begin
          // The reset is held long enough for every block to see it.
          if (rst_cnt_reg <= 1)
          begin
            sys_reg <= dcpmc_pkg::DCPMC_SYS_RUN;
          end
          rst_cnt_reg <= rst_cnt_reg - 1'b1;
        end
      endcase
    end
  end

  // Per-core outputs.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      core_clock_enable_out <= '1;
      core_sleeping_out <= '0;
    end
    else
    begin
      // Gating lags the state by one cycle; peripherals are never gated here.
      core_clock_enable_out <= ~sleep_reg &
        {NUM_CORES{sys_reg == dcpmc_pkg::DCPMC_SYS_RUN}};
      core_sleeping_out <= sleep_reg;
    end
  end

  // System outputs, registered from the current state.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      power_out <= power_for(dcpmc_pkg::DCPMC_SYS_RUN,
                             dcpmc_pkg::DCPMC_MODE_DEEP_SLEEP);
      active_mode_out <= dcpmc_pkg::DCPMC_MODE_DEEP_SLEEP;
      system_low_power_out <= 1'b0;
      chip_reset_n_out <= 1'b1;
    end
    else
    begin
      power_out <= power_for(sys_reg, mode_reg);
      active_mode_out <= mode_reg;
      system_low_power_out <= (sys_reg == dcpmc_pkg::DCPMC_SYS_LOW_POWER);
      chip_reset_n_out <= (sys_reg != dcpmc_pkg::DCPMC_SYS_RESET);
    end
  end
endmodule // dcpmc_controller

//--- test/dcpmc_monitor.sv
// Purpose: Port checker for the power mode controller.
// Assumes: One clock; outputs lag their cause by two edges.
// Notes: Bound onto the controller by the line after the module.
`timescale 1ns/1ns
module dcpmc_monitor #(
  parameter int RESET_CYCLES = 16
)
(
  input wire logic clk_in, rst_n_in, wake_pin_in, rtc_event_in,
  input wire logic alarm_event_in, system_low_power_out, chip_reset_n_out,
  input wire logic [1:0] wait_instruction_in, core_sleeping_out,
  input wire logic [1:0] core_interrupt_controller_wake_in,
  input wire logic [1:0] event_router_wake_in, core_clock_enable_out,
  input wire dcpmc_pkg::dcpmc_power_type power_out,
  input wire dcpmc_pkg::dcpmc_lp_mode_type active_mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence sys_wake_s;
    $past(wake_pin_in | rtc_event_in | alarm_event_in, 2);
  endsequence
  sequence core_wake_s;
    $past(core_interrupt_controller_wake_in[0] | event_router_wake_in[0], 2);
  endsequence
  wire logic run = !system_low_power_out && chip_reset_n_out;
  a_clock_gate: assert property (run |->
    core_clock_enable_out == ~core_sleeping_out) else $error("gating");
  a_run_power: assert property (run |-> power_out == 4'hf)
    else $error("run power");
  a_lp_shutdown: assert property (system_low_power_out |->
    power_out[3:2] == 2'b00 && power_out.always_on && !core_clock_enable_out)
    else $error("shutdown");
  a_mem_retain: assert property (system_low_power_out |->
    power_out.memory_on == (active_mode_out != 2'h2)) else $error("memory");
  a_entry_wait: assert property ($rose(system_low_power_out) |->
    $past(|wait_instruction_in, 2)) else $error("entry");
  a_exit_cause: assert property ($fell(system_low_power_out) |->
    sys_wake_s) else $error("exit");
  a_core_wake: assert property ($fell(core_sleeping_out[0]) &&
    !system_low_power_out |-> core_wake_s) else $error("core wake");
  a_reset_span: assert property ($rose(chip_reset_n_out) |->
    !$past(chip_reset_n_out, RESET_CYCLES) &&
    $past(chip_reset_n_out, RESET_CYCLES + 1)) else $error("span");
endmodule // dcpmc_monitor
bind dcpmc_controller dcpmc_monitor #(.RESET_CYCLES(RESET_CYCLES)) i_mon (.*);

//--- test/dcpmc_cores.sv
// Purpose: Two cores that run wait and request code.
// Assumes: Commands are one-cycle pulses.
// Notes: A core with a stopped clock runs no code.
`timescale 1ns/1ns
module dcpmc_cores (
  input wire logic clk_in,
  input wire logic [1:0] clk_en_in, req_cmd_in, wait_cmd_in,
  output logic [1:0] lp_request_out, wait_instruction_out
);
  always_ff @(posedge clk_in)
  begin
    lp_request_out <= req_cmd_in & clk_en_in;
    wait_instruction_out <= wait_cmd_in & clk_en_in;
  end
endmodule // dcpmc_cores

//--- test/test_dcpmc_controller.sv
// Purpose: Directed test of the power mode controller.
// Assumes: Reset pulse shortened to 4 cycles.
// Notes: Stimulus bits pack requests, waits and wake pulses.
`timescale 1ns/1ns
module test_dcpmc_controller;
  logic clk_in = 0, rst_n_in = 0, lp, crn;
  logic [1:0] en = 0, lreq, lwt, cke, slp;
  logic [10:0] s = 0;
  dcpmc_pkg::dcpmc_lp_mode_type md = dcpmc_pkg::DCPMC_MODE_DEEP_SLEEP, am;
  dcpmc_pkg::dcpmc_power_type pw;
  wire logic [7:0] st = {2'b00, lp, crn, cke, slp};
  int n_mismatch = 0, checked = 0;
  initial forever #10 clk_in = ~clk_in;
  dcpmc_cores i_dcpmc_cores (.clk_in, .clk_en_in(cke), .req_cmd_in(s[1:0]),
    .wait_cmd_in(s[3:2]), .lp_request_out(lreq), .wait_instruction_out(lwt));
  dcpmc_controller #(.RESET_CYCLES(4)) i_dcpmc_controller (.clk_in,
    .rst_n_in, .wait_instruction_in(lwt), .lp_enable_in(en),
    .lp_request_in(lreq), .lp_mode_in(md),
    .core_interrupt_controller_wake_in(s[5:4]),
    .event_router_wake_in(s[7:6]), .wake_pin_in(s[8]), .rtc_event_in(s[9]),
    .alarm_event_in(s[10]), .core_clock_enable_out(cke),
    .core_sleeping_out(slp), .power_out(pw), .active_mode_out(am),
    .system_low_power_out(lp), .chip_reset_n_out(crn));
  task automatic pulse(input logic [10:0] m, input int n);
    @(posedge clk_in);
    s <= m;
    @(posedge clk_in);
    s <= 11'h000;
    repeat (n) @(posedge clk_in);
  endtask
  task chk(input logic [7:0] got, exp);
    #1;
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task t_sleep;
    pulse(11'h004, 4);
    chk(st, 8'h19);
    pulse(11'h008, 4);
    chk(st, 8'h13);
    chk({4'h0, pw}, 8'h0f);
    pulse(11'h100, 4);
    chk(st, 8'h13);
    pulse(11'h010, 4);
    chk(st, 8'h16);
    pulse(11'h080, 4);
    chk(st, 8'h1c);
    $display("sleep test done");
  endtask
  task automatic t_sys(input int k);
    logic [7:0] lo;
    lo = 0;
    en <= 2'b11;
    md <= dcpmc_pkg::dcpmc_lp_mode_type'(k);
    pulse(11'h003, 4);
    pulse(11'h004, 4);
    chk({7'h00, lp}, 8'h00);
    pulse(11'h008, 4);
    chk(st, 8'h30);
    chk({4'h0, pw}, k == 2 ? 8'h01 : 8'h03);
    chk({6'h00, am}, 8'(k));
    pulse(11'h010, 4);
    chk({7'h00, lp}, 8'h01);
    pulse(11'h100 << k, 0);
    repeat (40)
    begin
      @(posedge clk_in);
      #1;
      lo += 8'(crn === 1'b0);
    end
    chk(lo, k == 2 ? 8'h04 : 8'h00);
    chk(st, 8'h1c);
    $display("system test %0d done", k);
  endtask
  task stop_test;
    $display("mismatches %0d checked %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk_in);
    n_mismatch++;
    stop_test;
  end
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_sleep;
    for (int k = 0; k < 3; k++)
      t_sys(k);
    stop_test;
  end
endmodule // test_dcpmc_controller
